//--- core/mcr_pkg.sv
// constants, types and helpers for the monitor configuration register group
package mcr_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SPARE = 8'h45;
    localparam logic [7:0] IDX_ICLR = 8'h46;
    localparam logic [7:0] IDX_VIDDIV = 8'h47;
    localparam logic [7:0] IDX_SADDR = 8'h48;
    localparam logic [7:0] IDX_VIDTOP = 8'h49;
    localparam logic [7:0] IDX_TCFG = 8'h4B;
    localparam logic [7:0] IDX_EXT1 = 8'h4C;
    localparam logic [7:0] IDX_EXT2 = 8'h4D;

    // values after reset
    localparam logic [7:0] RST_SPARE = 8'h00;
    localparam logic [6:0] RST_ICLR_LOW = 7'h00;
    localparam logic [3:0] RST_DIV = 4'h5;
    localparam logic [4:0] RST_SADDR_HI = 5'h0B;
    localparam logic [6:0] RST_VIDTOP_HI = 7'h40;
    localparam logic [6:0] RST_TCFG = 7'h01;
    localparam logic [6:0] RST_EXT1 = 7'h44;
    localparam logic [3:0] RST_EXT2 = 4'h0;

    // field positions
    localparam int ICLR_BIT = 7;
    localparam int EXT_EN_BIT = 0;
    localparam int LOW_MASK_BIT = 1;
    localparam int CRIT_EN_BIT = 4;
    localparam int CRIT_POL_BIT = 5;
    localparam int CRIT_MASK_BIT = 6;
    localparam int CRIT_STAT_BIT = 7;
    localparam int RES12_BIT = 3;

    // clear pulse timing: least time, cycles per ms rounded down
    localparam int CLK_HZ = 25_000_000;
    localparam int CLR_PULSE_MS = 20;
    localparam int CLR_PULSE_CYC = (CLK_HZ / 1000) * CLR_PULSE_MS;

    typedef enum logic [1:0] {
        MCR_REPEAT = 2'b00,
        MCR_ONCE = 2'b01,
        MCR_COMPARE = 2'b11
    } mcr_mode_t;

    typedef enum logic {
        MCR_PULSE_IDLE = 1'b0,
        MCR_PULSE_ON = 1'b1
    } mcr_pulse_t;

    typedef struct packed {
        logic ext_mode_en;
        logic low_mask;
        mcr_mode_t crit_mode;
        logic crit_pin_en;
        logic crit_active_high;
        logic crit_int_mask;
        logic twelve_bit_en;
        logic [2:0] hysteresis_offset;
    } mcr_ext_cfg_t;

    function automatic mcr_mode_t mcr_mode_decode(input logic [1:0] code);
        mcr_mode_decode = (code == 2'b01) ? MCR_ONCE : (code == 2'b10) ? MCR_COMPARE : MCR_REPEAT;
    endfunction : mcr_mode_decode

    function automatic logic [3:0] mcr_div_factor(input logic [1:0] code);
        mcr_div_factor = 4'h1 << code;
    endfunction : mcr_div_factor

endpackage : mcr_pkg

//--- core/mcr_regs.sv
// control and status register group of the hardware monitor, AHB-Lite slave
//
// Functional notes
// - reserved byte at 45h resets to 00h and stores any written value.
// - writing one to intrusion clear bit 7 drives a low pulse of 20 ms or more.
// - the intrusion clear bit drops to zero by itself after the pulse.
// - one clear bit shared with main configuration bit 6, writable from both.
// - bits 3:0 read voltage-id pins; bits 7:4 reset to 0101.
// - bits 5:4 select tach one prescaler: divide by 1, 2, 4, 8.
// - bits 7:6 select tach two prescaler: divide by 1, 2, 4, 8.
// - slave address bits 1:0 read strap pins, high strap in bit 1.
// - address bits 6:2 writable, reset 01011; bit 7 spare; device answers there.
// - bit 0 reads fifth voltage-id pin; bits 7:1 spare storage, reset 1000000.
// - temperature bits 1:0 pick interrupt mode; 00/11 repeat, 01 once, 10 compare.
// - temperature bit 7 reads half-degree result bit; bits 6:2 spare storage.
// - extended bit 0 enables extended functions and low-limit status bit 7.
// - extended bit 1 blocks the low-limit interrupt from the main interrupt.
// - extended bits 3:2 pick critical alert mode; 00/11 repeat, 01 once, 10 compare.
// - critical alert pin active only while extended bit 4 is one.
// - extended bit 5 sets alert polarity, one active high, zero active low.
// - extended bit 6 keeps critical alert off the main interrupt; resets one.
// - extended bit 7 is set by the device when a critical alert occurs.
// - extended two bit 3 selects 12-bit conversion; bits 2:0 hold hysteresis.
// - extended two bits 7:4 read the four low temperature fraction bits.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps

module mcr_regs #(
    parameter int PULSE_CYC = mcr_pkg::CLR_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic cfg_clear_wr,
    input wire logic cfg_clear_wdata,
    output logic intrusion_clear_bit,
    input wire logic chassis_intrusion_in,
    output logic chassis_intrusion_out,
    output logic chassis_intrusion_oe,
    input wire logic [3:0] processor_voltage_id_low,
    input wire logic processor_voltage_id_top,
    input wire logic address_strap_high,
    input wire logic address_strap_low,
    output logic [6:0] slave_address,
    output logic [3:0] tach_one_divisor,
    output logic [3:0] tach_two_divisor,
    input wire logic [3:0] temp_fraction,
    output mcr_pkg::mcr_mode_t temp_int_mode,
    output mcr_pkg::mcr_ext_cfg_t ext_cfg,
    input wire logic crit_over,
    input wire logic low_limit_flag,
    output logic low_limit_status,
    output logic low_int_req,
    output logic crit_int_req,
    output logic critical_temp_alert
);
    import mcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus address phase
    logic acc_ff;
    logic wr_ff;
    logic [7:0] idx_ff;
    logic take;
    logic [7:0] idx_now;
    logic addr_ok;

    assign take = hsel && htrans[1] && hready;
    assign idx_now = haddr[9:2];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // misaligned or out-of-range words read zero and drop writes, still OKAY
    assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h000000);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            acc_ff <= 1'b0;
        end else if (clk_en) begin
            acc_ff <= take && addr_ok;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ff <= 1'b0;
        end else if (clk_en) begin
            wr_ff <= hwrite;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            idx_ff <= 8'h00;
        end else if (clk_en) begin
            idx_ff <= idx_now;
        end
    end

    function automatic logic wr_to(input logic [7:0] idx);
        wr_to = acc_ff && wr_ff && (idx_ff == idx);
    endfunction : wr_to

    ////////////////////////////////////////////////////////////////////////
    // stored fields
    logic [7:0] spare_ff;
    logic [6:0] iclr_low_ff;
    logic [3:0] div_ff;
    logic [4:0] saddr_hi_ff;
    logic saddr_top_ff;
    logic [6:0] vidtop_hi_ff;
    logic [6:0] tcfg_ff;
    logic [6:0] ext1_ff;
    logic [3:0] ext2_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            spare_ff <= RST_SPARE;
        end else if (clk_en && wr_to(IDX_SPARE)) begin
            spare_ff <= hwdata[7:0];
        end
    end

    // bit 7 is the shared clear bit, kept in the pulse logic below
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            iclr_low_ff <= RST_ICLR_LOW;
        end else if (clk_en && wr_to(IDX_ICLR)) begin
            iclr_low_ff <= hwdata[6:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_ff <= RST_DIV;
        end else if (clk_en && wr_to(IDX_VIDDIV)) begin
            div_ff <= hwdata[7:4];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            saddr_hi_ff <= RST_SADDR_HI;
        end else if (clk_en && wr_to(IDX_SADDR)) begin
            saddr_hi_ff <= hwdata[6:2];
        end
    end

    // reserved top bit only stores; it is no part of the bus address
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            saddr_top_ff <= 1'b0;
        end else if (clk_en && wr_to(IDX_SADDR)) begin
            saddr_top_ff <= hwdata[7];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            vidtop_hi_ff <= RST_VIDTOP_HI;
        end else if (clk_en && wr_to(IDX_VIDTOP)) begin
            vidtop_hi_ff <= hwdata[7:1];
        end
    end

    // bit 7 reads the half-degree result, so only 6:0 are stored
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tcfg_ff <= RST_TCFG;
        end else if (clk_en && wr_to(IDX_TCFG)) begin
            tcfg_ff <= hwdata[6:0];
        end
    end

    // status bit 7 lives apart: hardware sets it and a read clears it
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ext1_ff <= RST_EXT1;
        end else if (clk_en && wr_to(IDX_EXT1)) begin
            ext1_ff <= hwdata[6:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ext2_ff <= RST_EXT2;
        end else if (clk_en && wr_to(IDX_EXT2)) begin
            ext2_ff <= hwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // intrusion clear pulse
    // a zero written while the pulse runs is ignored, so the pulse length
    // is always the full count
    mcr_pulse_t pulse_ff;
    logic [31:0] pulse_cnt_ff;
    logic clr_req;
    logic pulse_done;

    assign clr_req = (wr_to(IDX_ICLR) && hwdata[ICLR_BIT])
        || (cfg_clear_wr && cfg_clear_wdata);
    assign pulse_done = (pulse_cnt_ff >= 32'(PULSE_CYC - 1));

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pulse_ff <= MCR_PULSE_IDLE;
        end else if (clk_en) begin
            unique case (pulse_ff)
                MCR_PULSE_IDLE: begin
                    if (clr_req) begin
                        pulse_ff <= MCR_PULSE_ON;
                    end
                end
                MCR_PULSE_ON: begin
                    if (pulse_done) begin
                        pulse_ff <= MCR_PULSE_IDLE;
                    end
                end
            endcase
        end
    end

    // runs only while the pin is driven; requests seen meanwhile are dropped
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pulse_cnt_ff <= 32'h00000000;
        end else if (clk_en) begin
            if (pulse_ff == MCR_PULSE_IDLE) begin
                pulse_cnt_ff <= 32'h00000000;
            end else if (!pulse_done) begin
                pulse_cnt_ff <= pulse_cnt_ff + 32'h00000001;
            end
        end
    end

    assign intrusion_clear_bit = (pulse_ff == MCR_PULSE_ON);
    assign chassis_intrusion_out = 1'b0;
    assign chassis_intrusion_oe = intrusion_clear_bit;

    ////////////////////////////////////////////////////////////////////////
    // critical alert and low limit
    logic crit_stat_ff;
    logic crit_prev_ff;
    logic crit_rise;
    logic crit_stat_rd;
    logic crit_level;

    assign crit_rise = crit_over && !crit_prev_ff;
    assign crit_stat_rd = acc_ff && !wr_ff && (idx_ff == IDX_EXT1);

    // starts at the idle level of the condition, so no false edge after reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            crit_prev_ff <= 1'b0;
        end else if (clk_en) begin
            crit_prev_ff <= crit_over;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            crit_stat_ff <= 1'b0;
        end else if (clk_en) begin
            // set wins over the clear by read
            if (ext_cfg.ext_mode_en && crit_rise) begin
                crit_stat_ff <= 1'b1;
            end else if (crit_stat_rd) begin
                crit_stat_ff <= 1'b0;
            end
        end
    end

    // comparator mode follows the condition; the others hold until read
    assign crit_level = (ext_cfg.crit_mode == MCR_COMPARE) ? crit_over : crit_stat_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            // polarity resets to active low, so the idle pin level is high
            critical_temp_alert <= 1'b1;
        end else if (clk_en) begin
            critical_temp_alert <= ext_cfg.crit_active_high
                ~^ (ext_cfg.ext_mode_en && ext_cfg.crit_pin_en && crit_level);
        end
    end

    assign crit_int_req = ext_cfg.ext_mode_en && crit_level && !ext_cfg.crit_int_mask;
    assign low_limit_status = ext_cfg.ext_mode_en && low_limit_flag;
    assign low_int_req = low_limit_status && !ext_cfg.low_mask;

    ////////////////////////////////////////////////////////////////////////
    // decoded outputs
    assign ext_cfg.ext_mode_en = ext1_ff[EXT_EN_BIT];
    assign ext_cfg.low_mask = ext1_ff[LOW_MASK_BIT];
    assign ext_cfg.crit_mode = mcr_mode_decode(ext1_ff[3:2]);
    assign ext_cfg.crit_pin_en = ext1_ff[CRIT_EN_BIT];
    assign ext_cfg.crit_active_high = ext1_ff[CRIT_POL_BIT];
    assign ext_cfg.crit_int_mask = ext1_ff[CRIT_MASK_BIT];
    assign ext_cfg.twelve_bit_en = ext2_ff[RES12_BIT];
    assign ext_cfg.hysteresis_offset = ext2_ff[2:0];
    assign temp_int_mode = mcr_mode_decode(tcfg_ff[1:0]);
    assign tach_one_divisor = mcr_div_factor(div_ff[1:0]);
    assign tach_two_divisor = mcr_div_factor(div_ff[3:2]);
    assign slave_address = {saddr_hi_ff, address_strap_high, address_strap_low};

    ////////////////////////////////////////////////////////////////////////
    // read data, latched at the address phase
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        unique case (idx_now)
            IDX_SPARE: rd_byte = spare_ff;
            IDX_ICLR: rd_byte = {intrusion_clear_bit, iclr_low_ff};
            IDX_VIDDIV: rd_byte = {div_ff, processor_voltage_id_low};
            IDX_SADDR: rd_byte = {saddr_top_ff, slave_address};
            IDX_VIDTOP: rd_byte = {vidtop_hi_ff, processor_voltage_id_top};
            IDX_TCFG: rd_byte = {temp_fraction[3], tcfg_ff[6:0]};
            IDX_EXT1: rd_byte = {crit_stat_ff, ext1_ff};
            IDX_EXT2: rd_byte = {temp_fraction, ext2_ff};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && take) begin
            hrdata <= {24'h000000, addr_ok ? rd_byte : 8'h00};
        end
    end

endmodule : mcr_regs

//--- tb/mcr_regs_checker.sv
// port assertions for the monitor configuration register group
`timescale 1ns/100ps
module mcr_regs_checker #(
    parameter int PULSE_CYC = mcr_pkg::CLR_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic intrusion_clear_bit,
    input wire logic chassis_intrusion_out,
    input wire logic chassis_intrusion_oe,
    input wire logic address_strap_high,
    input wire logic address_strap_low,
    input wire logic [6:0] slave_address,
    input wire logic [3:0] tach_one_divisor,
    input wire logic [3:0] tach_two_divisor,
    input wire mcr_pkg::mcr_ext_cfg_t ext_cfg,
    input wire logic low_limit_flag,
    input wire logic low_limit_status,
    input wire logic low_int_req,
    input wire logic crit_int_req,
    input wire logic critical_temp_alert
);
    import mcr_pkg::*;
    int len_ff;
    // counts pulse cycles, cleared while the pin is released
    always_ff @(posedge mclk) begin
        if (!reset_n || !chassis_intrusion_oe) len_ff <= 0;
        else len_ff <= len_ff + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_pulse_start; $rose(chassis_intrusion_oe); endsequence
    sequence s_pulse_end; $fell(chassis_intrusion_oe); endsequence
    property p_bus; hreadyout && !hresp; endproperty
    property p_hold; !(hsel && htrans[1] && hready) |=> $stable(hrdata); endproperty
    property p_pulse_pin; s_pulse_start |-> intrusion_clear_bit && !chassis_intrusion_out; endproperty
    property p_pulse_len; s_pulse_end |-> len_ff == PULSE_CYC; endproperty
    property p_clr; chassis_intrusion_oe && len_ff < PULSE_CYC - 1 |=> intrusion_clear_bit; endproperty
    property p_strap; slave_address[1:0] == {address_strap_high, address_strap_low}; endproperty
    property p_div; $onehot(tach_one_divisor) && $onehot(tach_two_divisor); endproperty
    property p_low; low_limit_status == (ext_cfg.ext_mode_en && low_limit_flag); endproperty
    property p_lowmask; low_int_req == (low_limit_status && !ext_cfg.low_mask); endproperty
    property p_critmask; crit_int_req |-> ext_cfg.ext_mode_en && !ext_cfg.crit_int_mask; endproperty
    property p_alert;
        $stable(ext_cfg) && !ext_cfg.crit_pin_en |-> critical_temp_alert == !ext_cfg.crit_active_high;
    endproperty
    a_bus: assert property (p_bus) else $error("bus not zero wait okay");
    a_hold: assert property (p_hold) else $error("read data moved without transfer");
    a_pulse_pin: assert property (p_pulse_pin) else $error("pulse pin wrong");
    a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
    a_clr: assert property (p_clr) else $error("clear pulse cut short");
    a_strap: assert property (p_strap) else $error("strap bits wrong");
    a_div: assert property (p_div) else $error("divisor not a power of two");
    a_low: assert property (p_low) else $error("low status wrong");
    a_lowmask: assert property (p_lowmask) else $error("low mask wrong");
    a_critmask: assert property (p_critmask) else $error("critical mask wrong");
    a_alert: assert property (p_alert) else $error("alert not idle while disabled");
endmodule : mcr_regs_checker
bind mcr_regs mcr_regs_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.mclk, .reset_n, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .hrdata, .intrusion_clear_bit, .chassis_intrusion_out, .chassis_intrusion_oe,
    .address_strap_high, .address_strap_low, .slave_address, .tach_one_divisor, .tach_two_divisor,
    .ext_cfg, .low_limit_flag, .low_limit_status, .low_int_req, .crit_int_req, .critical_temp_alert);

//--- tb/mcr_host.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/100ps
module mcr_host (
    input wire logic mclk,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end
    // waits on hready with no assumed latency; the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata[7:0];
    endtask : xfer
endmodule : mcr_host

//--- tb/mcr_regs_tb.sv
// self-checking bench for the monitor configuration register group
`timescale 1ns/100ps
module mcr_regs_tb;
    import mcr_pkg::*;
    localparam int PCYC = 20;
    logic mclk = 0, reset_n = 0, clk_en = 1, hsel = 1, hwrite, hreadyout, hresp, hready;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize = 3'h2;
    logic cfg_clear_wr = 0, cfg_clear_wdata = 0, intrusion_clear_bit, chassis_intrusion_in = 1;
    logic chassis_intrusion_out, chassis_intrusion_oe, processor_voltage_id_top = 1;
    logic [3:0] processor_voltage_id_low = 4'h6, temp_fraction = 4'hA, tach_one_divisor, tach_two_divisor;
    logic address_strap_high = 1, address_strap_low = 0, crit_over = 0, low_limit_flag = 1;
    logic low_limit_status, low_int_req, crit_int_req, critical_temp_alert;
    logic [6:0] slave_address;
    mcr_mode_t temp_int_mode;
    mcr_ext_cfg_t ext_cfg;
    logic [7:0] d;
    int error_cnt = 0, comparisons = 0;
    assign hready = hreadyout;
    mcr_regs #(.PULSE_CYC(PCYC)) u_dut (.mclk, .reset_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hresp, .hrdata, .cfg_clear_wr, .cfg_clear_wdata, .intrusion_clear_bit,
        .chassis_intrusion_in, .chassis_intrusion_out, .chassis_intrusion_oe, .processor_voltage_id_low,
        .processor_voltage_id_top, .address_strap_high, .address_strap_low, .slave_address,
        .tach_one_divisor, .tach_two_divisor, .temp_fraction, .temp_int_mode, .ext_cfg, .crit_over,
        .low_limit_flag, .low_limit_status, .low_int_req, .crit_int_req, .critical_temp_alert);
    mcr_host u_host (.mclk, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata);
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        u_host.xfer(1'b1, i, v, d);
        @(posedge mclk);
    endtask : wr
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        u_host.xfer(1'b0, i, 8'h00, d);
        chk($sformatf("reg %h", i), d, e);
    endtask : rc
    task automatic test_done;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] ri[9] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4B, 8'h4C, 8'h4D, 8'h4A};
        logic [7:0] re[9] = '{8'h00, 8'h00, 8'h56, 8'h2E, 8'h81, 8'h81, 8'h44, 8'hA0, 8'h00};
        for (int k = 0; k < 9; k++) rc(ri[k], re[k]);
        chk("low status", low_limit_status, 1'b0);
    endtask : t_reset
    task automatic t_rw;
        logic [7:0] wi[7] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4B, 8'h4D};
        logic [7:0] wv[7] = '{8'hA5, 8'h55, 8'hC0, 8'hFF, 8'h00, 8'h7E, 8'h0D};
        logic [7:0] we[7] = '{8'hA5, 8'h55, 8'hC6, 8'hFE, 8'h01, 8'hFE, 8'hAD};
        mcr_mode_t me[4] = '{MCR_REPEAT, MCR_ONCE, MCR_COMPARE, MCR_REPEAT};
        for (int k = 0; k < 7; k++) wr(wi[k], wv[k]);
        for (int k = 0; k < 7; k++) rc(wi[k], we[k]);
        clk_en <= 1'b0;
        wr(8'h45, 8'h5A);
        clk_en <= 1'b1;
        rc(8'h45, 8'hA5);
        chk("slave address", slave_address, 7'h7E);
        chk("ext two", {ext_cfg.twelve_bit_en, ext_cfg.hysteresis_offset}, 4'hD);
        for (int c = 0; c < 4; c++) begin
            wr(8'h47, {c[1:0], 2'(3 - c), 4'h0});
            chk("tach one", tach_one_divisor, 4'h1 << (3 - c));
            chk("tach two", tach_two_divisor, 4'h1 << c);
            wr(8'h4B, {6'h00, c[1:0]});
            chk("temp mode", temp_int_mode, me[c]);
            wr(8'h4C, {4'h0, c[1:0], 2'b00});
            chk("crit mode", ext_cfg.crit_mode, me[c]);
        end
    endtask : t_rw
    task automatic t_pulse;
        wr(8'h46, 8'h80);
        chk("pin drive", {chassis_intrusion_oe, chassis_intrusion_out}, 2'b10);
        wr(8'h46, 8'h00);
        wr(8'h46, 8'h80);
        rc(8'h46, 8'h80);
        repeat (PCYC) @(posedge mclk);
        rc(8'h46, 8'h00);
        chk("pin free", chassis_intrusion_oe, 1'b0);
        cfg_clear_wr <= 1;
        cfg_clear_wdata <= 1;
        @(posedge mclk);
        cfg_clear_wr <= 0;
        rc(8'h46, 8'h80);
        repeat (PCYC) @(posedge mclk);
        rc(8'h46, 8'h00);
    endtask : t_pulse
    task automatic t_ext;
        wr(8'h4C, 8'h03);
        chk("low req", {low_limit_status, low_int_req}, 2'b10);
        wr(8'h4C, 8'h01);
        chk("low req", low_int_req, 1'b1);
        wr(8'h4C, 8'h39);
        crit_over <= 1;
        repeat (2) @(posedge mclk);
        chk("crit req", {crit_int_req, critical_temp_alert}, 2'b11);
        rc(8'h4C, 8'hB9);
        rc(8'h4C, 8'h39);
        wr(8'h4C, 8'h19);
        @(posedge mclk);
        chk("alert low", critical_temp_alert, 1'b0);
        wr(8'h4C, 8'h69);
        @(posedge mclk);
        chk("alert off", {critical_temp_alert, crit_int_req}, 2'b00);
    endtask : t_ext
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        t_reset();
        t_rw();
        t_pulse();
        t_ext();
        test_done();
    end
endmodule : mcr_regs_tb
